// ---- cbt_bit_timing.sv ----
// bit timing logic: quantum prescaler, segment sequencer, edge resync
// assumes i_rx is already synchronous to i_core_clk
`timescale 1ns/1ps
// Behaviour
// - four segments: sync, prop, phase1, phase2
// - bit time is quanta summed over segments
// - total bit length 8 to 25 quanta
// - quantum is two times (prescaler plus one) core cycles
// - prescaler six bits, values 0 to 63
// - bit time at least one microsecond
// - same bit rate on every node
// - stuffing gives edges every six bits
// - edges lock receive and transmit timing
// - timing sets sync, delay, sample point
module cbt_bit_timing (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// configuration
	input wire logic [cbt_pkg::PRESC_W-1:0] i_quantum_prescaler_value,
	input wire logic [cbt_pkg::SEG_W-1:0] i_prop_seg,
	input wire logic [cbt_pkg::SEG_W-1:0] i_first_phase_buffer,
	input wire logic [cbt_pkg::SEG_W-1:0] i_second_phase_buffer,
	input wire logic [cbt_pkg::SEG_W-1:0] i_sjw,
	// bus
	input wire logic i_rx,
	input wire logic i_tx_bit,
	output logic o_tx,
	// status
	output logic o_sample,
	output logic o_rx_bit,
	output logic o_bit_start,
	output logic o_tq_tick,
	output logic [1:0] o_seg,
	output logic o_cfg_err
);
	import cbt_pkg::*;

	// ----------------------------------------
	// configuration check
	// ----------------------------------------
	logic [5:0] total_tq;
	logic cfg_ok;
	// rate set by presc and quanta
	always_comb begin
		total_tq = 6'(SYNC_TQ) + 6'(i_prop_seg) + 6'(i_first_phase_buffer)
			+ 6'(i_second_phase_buffer);
		cfg_ok = (total_tq >= 6'(BIT_TQ_MIN)) && (total_tq <= 6'(BIT_TQ_MAX))
			&& (i_prop_seg != '0) && (i_first_phase_buffer != '0)
			&& (i_second_phase_buffer != '0)
			&& ((32'(total_tq) * FIXED_DIV * (32'(i_quantum_prescaler_value) + 1))
				>= BIT_CYC_MIN);
	end

	// ----------------------------------------
	// quantum prescaler
	// ----------------------------------------
	logic [PRESC_W:0] pre_cnt_r, pre_cnt_nxt;
	logic tq_tick;
	always_comb begin
		// quantum divider
		// a lowered prescaler must not let the count run on past its end
		tq_tick = (pre_cnt_r >= {i_quantum_prescaler_value, 1'b1});
		pre_cnt_nxt = tq_tick ? '0 : pre_cnt_r + 7'h01;
	end
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			pre_cnt_r <= '0;
		end else begin
			pre_cnt_r <= pre_cnt_nxt;
		end
	end

	// ----------------------------------------
	// segment sequencer and resync
	// ----------------------------------------
	cbt_seg_t seg_r, seg_nxt;
	logic [SEG_W:0] tq_r, tq_nxt;
	logic [SEG_W:0] ph2_len_r, ph2_len_nxt;
	logic rx_prev_r, rx_prev_nxt;
	logic rx_bit_r, rx_bit_nxt;
	logic tx_r, tx_nxt;
	logic sample_r, sample_nxt;
	logic start_r, start_nxt;
	logic edge_seen_r, edge_seen_nxt;
	logic rx_fall;
	logic [SEG_W:0] seg_len;

	always_comb begin
		rx_fall = cfg_ok && rx_prev_r && !i_rx;
		unique case (seg_r)
			CBT_SYNC: seg_len = 5'(SYNC_TQ);
			CBT_PROP: seg_len = {1'b0, i_prop_seg};
			CBT_PH1: seg_len = {1'b0, i_first_phase_buffer};
			CBT_PH2: seg_len = ph2_len_r;
		endcase
		seg_nxt = seg_r;
		tq_nxt = tq_r;
		ph2_len_nxt = ph2_len_r;
		rx_prev_nxt = i_rx;
		rx_bit_nxt = rx_bit_r;
		tx_nxt = tx_r;
		sample_nxt = 1'b0;
		start_nxt = 1'b0;
		edge_seen_nxt = edge_seen_r | rx_fall;
		if (!cfg_ok) begin
			seg_nxt = CBT_SYNC;
			tq_nxt = '0;
			tx_nxt = 1'b1;
			edge_seen_nxt = 1'b0;
		end else if (rx_fall && seg_r == CBT_PH2 && !edge_seen_r) begin
			// early edge shortens phase2, restart bit
			seg_nxt = CBT_SYNC;
			tq_nxt = '0;
			start_nxt = 1'b1;
			tx_nxt = i_tx_bit;
			edge_seen_nxt = 1'b0;
		end else if (tq_tick) begin
			if (tq_r + 5'h01 >= seg_len) begin
				tq_nxt = '0;
				unique case (seg_r)
					CBT_SYNC: seg_nxt = CBT_PROP;
					CBT_PROP: seg_nxt = CBT_PH1;
					CBT_PH1: begin
						seg_nxt = CBT_PH2;
						sample_nxt = 1'b1;
						rx_bit_nxt = i_rx;
						ph2_len_nxt = {1'b0, i_second_phase_buffer};
					end
					CBT_PH2: begin
						seg_nxt = CBT_SYNC;
						start_nxt = 1'b1;
						tx_nxt = i_tx_bit;
						edge_seen_nxt = 1'b0;
					end
				endcase
			end else begin
				tq_nxt = tq_r + 5'h01;
			end
		end
		// late edge in prop/phase1 lengthens that segment by up to sjw
		if (cfg_ok && rx_fall && !edge_seen_r && (seg_r == CBT_PROP || seg_r == CBT_PH1)
			&& !(tq_tick && seg_r == CBT_PH1 && tq_r + 5'h01 >= seg_len)) begin
			if (tq_nxt >= {1'b0, i_sjw}) begin
				tq_nxt = tq_nxt - {1'b0, i_sjw};
			end else begin
				tq_nxt = '0;
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			seg_r <= CBT_SYNC;
			tq_r <= '0;
			ph2_len_r <= 5'(PH2_RST);
			rx_prev_r <= 1'b1;
			rx_bit_r <= 1'b1;
			tx_r <= 1'b1;
			sample_r <= 1'b0;
			start_r <= 1'b0;
			edge_seen_r <= 1'b0;
		end else begin
			seg_r <= seg_nxt;
			tq_r <= tq_nxt;
			ph2_len_r <= ph2_len_nxt;
			rx_prev_r <= rx_prev_nxt;
			rx_bit_r <= rx_bit_nxt;
			tx_r <= tx_nxt;
			sample_r <= sample_nxt;
			start_r <= start_nxt;
			edge_seen_r <= edge_seen_nxt;
		end
	end

	assign o_tx = tx_r;
	assign o_sample = sample_r;
	assign o_rx_bit = rx_bit_r;
	assign o_bit_start = start_r;
	assign o_tq_tick = tq_tick;
	assign o_seg = seg_r;
	assign o_cfg_err = !cfg_ok;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	// bit length watch: core cycles since the last bit start, and whether
	// the prescaler or segment inputs (not i_sjw) moved during that bit
	logic [PRESC_W+3*SEG_W-1:0] cfg_now, cfg_prev_r, cfg_prev_nxt;
	logic [11:0] bit_cyc_r, bit_cyc_nxt;
	logic cfg_moved_r, cfg_moved_nxt;
	always_comb begin
		cfg_now = {i_quantum_prescaler_value, i_prop_seg, i_first_phase_buffer,
			i_second_phase_buffer};
		cfg_prev_nxt = cfg_now;
		bit_cyc_nxt = (bit_cyc_r == 12'hfff) ? bit_cyc_r : bit_cyc_r + 12'h001;
		cfg_moved_nxt = cfg_moved_r || (cfg_now != cfg_prev_r);
		if (start_r) begin
			bit_cyc_nxt = 12'h001;
			cfg_moved_nxt = (cfg_now != cfg_prev_r);
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			cfg_prev_r <= '0;
			bit_cyc_r <= '0;
			cfg_moved_r <= 1'b1;
		end else begin
			cfg_prev_r <= cfg_prev_nxt;
			bit_cyc_r <= bit_cyc_nxt;
			cfg_moved_r <= cfg_moved_nxt;
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_ph1_end;
		seg_r == CBT_PH1 && seg_nxt == CBT_PH2;
	endsequence

	chk_seg_order: assert property (
		seg_r != $past(seg_r) |-> (seg_r == CBT_SYNC
			|| seg_r == cbt_seg_t'($past(seg_r) + 2'h1)))
		else $error("segment order broken");
	chk_tick_period: assert property (
		tq_tick && $stable(i_quantum_prescaler_value) |=> !tq_tick && pre_cnt_r == '0)
		else $error("quantum tick too close");
	chk_presc_range: assert property (
		pre_cnt_r <= {i_quantum_prescaler_value, 1'b1} || $changed(i_quantum_prescaler_value))
		else $error("prescaler count overran");
	chk_sample_point: assert property (
		s_ph1_end |=> sample_r && seg_r == CBT_PH2)
		else $error("sample not at phase1 end");
	chk_sync_len: assert property (
		seg_r == CBT_SYNC && tq_tick && cfg_ok && !rx_fall |=> seg_r == CBT_PROP)
		else $error("sync segment not one quantum");
	chk_tx_change: assert property (
		$changed(tx_r) && cfg_ok |-> start_r)
		else $error("tx changed outside bit start");
	chk_bad_cfg: assert property (
		!cfg_ok |=> seg_r == CBT_SYNC && tx_r)
		else $error("bad config not held idle");
	chk_start_sync: assert property (
		start_r |-> seg_r == CBT_SYNC && tq_r == '0)
		else $error("bit start not at sync");
	chk_min_bit: assert property (
		start_r && !cfg_moved_r && !$past(rx_fall) |-> bit_cyc_r >= 12'(BIT_CYC_MIN))
		else $error("bit time below minimum");
endmodule : cbt_bit_timing

// ---- cbt_pkg.sv ----
// bit timing constants for the can bit timing block
// assumes a single 40 MHz core clock
package cbt_pkg;
	localparam int unsigned CLK_PERIOD_PS = 25000;
	localparam int unsigned PRESC_W = 6;
	localparam int unsigned PRESC_LSB = 0;
	localparam int unsigned SEG_W = 4;
	localparam int unsigned BIT_TQ_MIN = 8;
	localparam int unsigned BIT_TQ_MAX = 25;
	localparam int unsigned SYNC_TQ = 1;
	localparam int unsigned FIXED_DIV = 2;
	// least nominal bit time in ns, and in core cycles (rounded up)
	localparam int unsigned BIT_TIME_MIN_NS = 1000;
	localparam int unsigned BIT_CYC_MIN = (BIT_TIME_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam logic [PRESC_W-1:0] PRESC_RST = 6'h00;
	localparam logic [SEG_W-1:0] PROP_RST = 4'h1;
	localparam logic [SEG_W-1:0] PH1_RST = 4'h3;
	localparam logic [SEG_W-1:0] PH2_RST = 4'h3;
	typedef enum logic [1:0] {CBT_SYNC, CBT_PROP, CBT_PH1, CBT_PH2} cbt_seg_t;
endpackage : cbt_pkg

// ---- cbt_bus_node.sv ----
// other node on the shared bus, modelled as a wired-and
// assumes the bench sets the node level just after a clock edge
`timescale 1ns/1ps
module cbt_bus_node (
	// bus levels
	input wire logic i_dev_tx,
	input wire logic i_node_tx,
	output logic o_bus
);
	// node shares rate
	// dominant 0 from either node wins the wire
	assign o_bus = i_dev_tx & i_node_tx;
endmodule : cbt_bus_node

// ---- test_can_bit_timing_logic.sv ----
// self-checking bench for the bit timing block
// assumes one 40 MHz clock and a wired-and bus node model
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
	$display("mismatch %s exp %0d got %0d", nm, e, g); end end
module test_can_bit_timing_logic;
	import cbt_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, tx_bit = 1'b1, node_tx = 1'b1;
	logic [PRESC_W-1:0] presc = 6'h02;
	logic [SEG_W-1:0] prop = 4'h1, ph1 = 4'h3, ph2 = 4'h3, sjw = 4'h1;
	logic bus, tx, smp, rx_bit, bstart, tick, cerr;
	logic [1:0] seg;
	logic [17:0] bad [4] = '{{6'h02, 4'h1, 4'h3, 4'h2}, {6'h00, 4'h8, 4'h8, 4'h9},
		{6'h01, 4'h1, 4'h3, 4'h3}, {6'h02, 4'h0, 4'h4, 4'h3}};
	int failures = 0, n_compared = 0, n;
	always #12.5 clk = ~clk;
	cbt_bit_timing u_cbt_bit_timing (.i_core_clk(clk), .i_rst_n(rst_n),
		.i_quantum_prescaler_value(presc), .i_prop_seg(prop), .i_first_phase_buffer(ph1),
		.i_second_phase_buffer(ph2), .i_sjw(sjw), .i_rx(bus), .i_tx_bit(tx_bit), .o_tx(tx),
		.o_sample(smp), .o_rx_bit(rx_bit), .o_bit_start(bstart), .o_tq_tick(tick),
		.o_seg(seg), .o_cfg_err(cerr));
	cbt_bus_node u_cbt_bus_node (.i_dev_tx(tx), .i_node_tx(node_tx), .o_bus(bus));
	// ----------------
	// tasks
	// ----------------
	task automatic tally_and_finish();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	// sel 0 bit start, 1 sample, 2 quantum tick
	task automatic wait_for(input int sel, output int c);
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while (!((sel == 0) ? bstart === 1'b1 : (sel == 1) ? smp === 1'b1 : tick === 1'b1)
			&& c < 3000);
		if (c >= 3000) begin
			failures++;
			tally_and_finish();
		end
	endtask : wait_for
	task automatic cfg(input logic [17:0] v);
		@(posedge clk);
		{presc, prop, ph1, ph2} <= v;
	endtask : cfg
	task automatic t_period(input int p, a, b, c);
		int q;
		q = 2 * (p + 1);
		cfg({p[5:0], a[3:0], b[3:0], c[3:0]});
		wait_for(0, n);
		wait_for(0, n);
		`CHK("cfg_err", 1'b0, cerr)
		wait_for(1, n);
		`CHK("to_sample", q * (1 + a + b), n)
		wait_for(0, n);
		`CHK("phase2", q * c, n)
		wait_for(0, n);
		`CHK("bit_time", q * (1 + a + b + c), n)
		wait_for(2, n);
		wait_for(2, n);
		`CHK("quantum", q, n)
	endtask : t_period
	task automatic t_refused();
		foreach (bad[i]) begin
			cfg(bad[i]);
			repeat (3) @(negedge clk);
			`CHK("cfg_err", 1'b1, cerr)
			`CHK("held_seg", 2'h0, seg)
			`CHK("held_tx", 1'b1, tx)
		end
	endtask : t_refused
	task automatic t_loop();
		cfg({6'h02, 4'h1, 4'h3, 4'h3});
		tx_bit <= 1'b0;
		wait_for(0, n);
		wait_for(0, n);
		`CHK("tx", 1'b0, tx)
		wait_for(1, n);
		`CHK("rx_bit", 1'b0, rx_bit)
		@(posedge clk);
		tx_bit <= 1'b1;
		wait_for(0, n);
		wait_for(0, n);
		`CHK("tx_idle", 1'b1, tx)
	endtask : t_loop
	task automatic t_resync();
		wait_for(1, n);
		repeat (6) @(posedge clk);
		node_tx <= 1'b0;
		wait_for(0, n);
		`CHK("early_start", 1'b1, n < 6)
		@(posedge clk);
		node_tx <= 1'b1;
	endtask : t_resync
	// edge one quantum into phase1: sample moves out by sjw quanta
	task automatic t_late();
		wait_for(0, n);
		repeat (20) @(posedge clk);
		node_tx <= 1'b0;
		wait_for(1, n);
		`CHK("late_sample", 6 * (1 + 1 + 3 + 1) - 19, n)
		`CHK("late_rx_bit", 1'b0, rx_bit)
		@(posedge clk);
		node_tx <= 1'b1;
	endtask : t_late
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(negedge clk);
		`CHK("rst_tx", 1'b1, tx)
		`CHK("rst_seg", 2'h0, seg)
		t_period(2, 1, 3, 3);
		t_period(0, 8, 8, 8);
		t_period(63, 1, 3, 3);
		t_refused();
		t_loop();
		t_resync();
		t_late();
		tally_and_finish();
	end
endmodule : test_can_bit_timing_logic
